/* File: nbci_top.sv */
// nand bus command decoder, address assembly and data paths with input fifo
`include "nbci_consts.svh"

module nbci_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module nbci_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wide_bus,
  input wire nbci_pkg::nbci_ctl_t ctl,
  input wire logic wp_n,
  input wire logic [15:0] io_in,
  output logic [15:0] io_out,
  output logic [15:0] io_oe,
  output logic busy_indicator_o,
  output logic busy_indicator_oe,
  input wire logic core_busy,
  output nbci_pkg::nbci_req_t req,
  output logic req_valid,
  output logic [15:0] din_data,
  output logic din_valid,
  input wire logic din_ready,
  input wire logic [15:0] dout_data,
  input wire logic dout_valid,
  output logic dout_ready
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA_IN,
    ST_DATA_OUT
  } nbci_state_t;

  nbci_state_t state_r;
  nbci_pkg::nbci_op_t pend_r;
  logic we_q_r;
  logic re_q_r;
  logic half_r;
  logic spare_r;
  logic cb_armed_r;
  logic [2:0] addr_cnt_r;
  logic [25:0] addr_r;
  logic [15:0] io_out_r;
  logic req_valid_r;
  nbci_pkg::nbci_req_t req_r;
  logic we_rise;
  logic re_fall;
  logic cmd_stb;
  logic addr_stb;
  logic data_stb;
  logic [7:0] cmd;
  logic addr_last;
  logic fifo_in_ready;
  logic [15:0] din_word;

  // strobes are sampled by the system clock; edges found by comparing with last sample
  assign we_rise = ctl.we_n & ~we_q_r;
  assign re_fall = ~ctl.re_n & re_q_r;
  // chip enable high masks every strobe, giving standby
  assign cmd_stb = we_rise & ~ctl.ce_n & ctl.command_latch_enable & ~ctl.address_latch_enable & ctl.re_n;
  assign addr_stb = we_rise & ~ctl.ce_n & ctl.address_latch_enable & ~ctl.command_latch_enable & ctl.re_n;
  assign data_stb = we_rise & ~ctl.ce_n & ~ctl.address_latch_enable & ~ctl.command_latch_enable & ctl.re_n
                    & (state_r == ST_DATA_IN);
  assign cmd = io_in[7:0];
  assign addr_last = addr_stb & (state_r == ST_ADDR) & (addr_cnt_r == `NBCI_ADDR_CYCLES - 3'h1);
  assign din_word = wide_bus ? io_in : {8'h00, io_in[7:0]};

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      we_q_r <= 1'b1;
      re_q_r <= 1'b1;
    end
    else
    begin
      // history parks at idle while deselected, so selecting with write strobe low makes no false edge; with read strobe low it makes a read fall
      we_q_r <= ctl.we_n | ctl.ce_n;
      re_q_r <= ctl.re_n | ctl.ce_n;
    end
  end

  // command decoder and sequence tracking
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      pend_r <= nbci_pkg::NBCI_OP_NONE;
      half_r <= 1'b0;
      spare_r <= 1'b0;
      cb_armed_r <= 1'b0;
      req_valid_r <= 1'b0;
      req_r <= '0;
    end
    else
    begin
      req_valid_r <= 1'b0;
      if (cmd_stb)
      begin
        if (cmd == `NBCI_CMD_RESET)
        begin
          state_r <= ST_IDLE;
          pend_r <= nbci_pkg::NBCI_OP_NONE;
          half_r <= 1'b0;
          spare_r <= 1'b0;
          cb_armed_r <= 1'b0;
          req_valid_r <= 1'b1;
          req_r <= '{op: nbci_pkg::NBCI_OP_RESET, spare_area: 1'b0, addr: '0};
        end
        else if (cmd == `NBCI_CMD_STATUS)
        begin
          state_r <= ST_DATA_OUT;
          req_valid_r <= 1'b1;
          req_r <= '{op: nbci_pkg::NBCI_OP_STATUS, spare_area: spare_r, addr: addr_r};
        end
        else if (!core_busy)
        begin
          case (cmd)
            `NBCI_CMD_READ_A:
            begin
              half_r <= 1'b0;
              spare_r <= 1'b0;
              pend_r <= nbci_pkg::NBCI_OP_READ;
              state_r <= ST_ADDR;
            end
            `NBCI_CMD_READ_B:
            begin
              if (!wide_bus)
              begin
                half_r <= 1'b1;
                spare_r <= 1'b0;
                pend_r <= nbci_pkg::NBCI_OP_READ;
                state_r <= ST_ADDR;
              end
            end
            `NBCI_CMD_READ_C:
            begin
              spare_r <= 1'b1;
              half_r <= 1'b0;
              pend_r <= nbci_pkg::NBCI_OP_READ;
              state_r <= ST_ADDR;
            end
            `NBCI_CMD_SIG:
            begin
              state_r <= ST_DATA_OUT;
              req_valid_r <= 1'b1;
              req_r <= '{op: nbci_pkg::NBCI_OP_SIG, spare_area: 1'b0, addr: '0};
            end
            `NBCI_CMD_PROG:
            begin
              pend_r <= nbci_pkg::NBCI_OP_PROG;
              state_r <= ST_ADDR;
            end
            `NBCI_CMD_ERASE:
            begin
              pend_r <= nbci_pkg::NBCI_OP_ERASE;
              state_r <= ST_ADDR;
            end
            `NBCI_CMD_COPYBACK:
            begin
              if (cb_armed_r)
              begin
                pend_r <= nbci_pkg::NBCI_OP_COPYBACK;
                state_r <= ST_ADDR;
              end
            end
            `NBCI_CMD_PROG_CONF:
            begin
              // a trailing confirm after copy back is taken and does nothing
              if (pend_r == nbci_pkg::NBCI_OP_PROG && state_r == ST_DATA_IN && wp_n)
              begin
                req_valid_r <= 1'b1;
                req_r <= '{op: nbci_pkg::NBCI_OP_PROG, spare_area: spare_r, addr: addr_r};
                half_r <= 1'b0;
              end
              pend_r <= nbci_pkg::NBCI_OP_NONE;
              state_r <= ST_IDLE;
            end
            `NBCI_CMD_ERASE_CONF:
            begin
              if (pend_r == nbci_pkg::NBCI_OP_ERASE && wp_n)
              begin
                req_valid_r <= 1'b1;
                req_r <= '{op: nbci_pkg::NBCI_OP_ERASE, spare_area: 1'b0, addr: addr_r};
              end
              pend_r <= nbci_pkg::NBCI_OP_NONE;
              state_r <= ST_IDLE;
            end
            default:
            begin
              state_r <= state_r;
            end
          endcase
          if (cmd != `NBCI_CMD_READ_A)
            cb_armed_r <= 1'b0;
        end
      end
      else if (addr_last)
      begin
        case (pend_r)
          nbci_pkg::NBCI_OP_READ:
          begin
            req_valid_r <= 1'b1;
            req_r <= '{op: nbci_pkg::NBCI_OP_READ, spare_area: spare_r, addr: {io_in[0], addr_r[24:0]}};
            half_r <= 1'b0;
            cb_armed_r <= 1'b1;
            state_r <= ST_DATA_OUT;
          end
          nbci_pkg::NBCI_OP_PROG:
          begin
            state_r <= ST_DATA_IN;
          end
          nbci_pkg::NBCI_OP_COPYBACK:
          begin
            if (wp_n)
            begin
              req_valid_r <= 1'b1;
              req_r <= '{op: nbci_pkg::NBCI_OP_COPYBACK, spare_area: 1'b0, addr: {io_in[0], addr_r[24:0]}};
            end
            cb_armed_r <= 1'b0;
            pend_r <= nbci_pkg::NBCI_OP_NONE;
            state_r <= ST_IDLE;
          end
          default:
          begin
            state_r <= ST_ADDR; // erase waits for its confirm
          end
        endcase
      end
    end
  end

  // address assembly; a fifth or later cycle leaves everything unchanged
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      addr_cnt_r <= 3'h0;
      addr_r <= '0;
    end
    else if (cmd_stb)
      addr_cnt_r <= 3'h0;
    else if (addr_stb && state_r == ST_ADDR && addr_cnt_r < `NBCI_ADDR_CYCLES)
    begin
      addr_cnt_r <= addr_cnt_r + 3'h1;
      case (addr_cnt_r)
        3'h0: addr_r[7:0] <= io_in[7:0];
        3'h1: addr_r[16:9] <= io_in[7:0];
        3'h2: addr_r[24:17] <= io_in[7:0];
        3'h3: addr_r[25] <= io_in[0];
        default: addr_r <= addr_r;
      endcase
      addr_r[`NBCI_HALF_BIT] <= half_r & ~wide_bus;
    end
  end

  nbci_fifo #(
    .WIDTH(`NBCI_IO_W),
    .DEPTH(`NBCI_FIFO_DEPTH)
  ) u_din_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(data_stb),
    .in_ready(fifo_in_ready),
    .in_data(din_word),
    .out_valid(din_valid),
    .out_ready(din_ready),
    .out_data(din_data)
  );

  // a strobe cannot be stalled, so a full fifo shows busy to make the host wait
  assign busy_indicator_o = 1'b0;
  assign busy_indicator_oe = core_busy | ~fifo_in_ready;

  // each read falling edge in data output, with both latch enables low, takes the next word from the core
  assign dout_ready = re_fall & ~ctl.ce_n & ~ctl.address_latch_enable & ~ctl.command_latch_enable
                      & ctl.we_n & (state_r == ST_DATA_OUT);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      io_out_r <= 16'h0000;
    else if (dout_ready)
      io_out_r <= dout_valid ? (wide_bus ? dout_data : {8'h00, dout_data[7:0]}) : 16'h0000;
  end

  assign io_out = io_out_r;
  assign io_oe = {16{~ctl.ce_n & ~ctl.address_latch_enable & ~ctl.command_latch_enable & ctl.we_n
                     & (state_r == ST_DATA_OUT)}};
  assign req = req_r;
  assign req_valid = req_valid_r;

  AST_OE_DOUT_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    io_oe[0] |-> state_r == ST_DATA_OUT && !ctl.command_latch_enable && !ctl.address_latch_enable)
    else $error("io driven outside data output");
  AST_OE_WE_HIGH: assert property (@(posedge clk) disable iff (!nrst)
    io_oe[15] |-> ctl.we_n && io_oe == {16{1'b1}})
    else $error("io driven while write strobe low");
  AST_STANDBY: assert property (@(posedge clk) disable iff (!nrst)
    ctl.ce_n |-> io_oe == 16'h0000 && !dout_ready && !data_stb)
    else $error("activity while deselected");
  AST_WP_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && (req.op == nbci_pkg::NBCI_OP_PROG || req.op == nbci_pkg::NBCI_OP_ERASE) |-> $past(wp_n))
    else $error("program or erase issued under write guard");
  AST_CMD_COND: assert property (@(posedge clk) disable iff (!nrst)
    cmd_stb |-> $past(ctl.we_n) == 1'b0 && !ctl.address_latch_enable && !ctl.ce_n)
    else $error("command latched in wrong bus state");
  AST_ADDR_SAT: assert property (@(posedge clk) disable iff (!nrst)
    addr_cnt_r == 3'h4 && addr_stb && !cmd_stb |=> addr_r == $past(addr_r) && addr_cnt_r == 3'h4)
    else $error("extra address cycle changed the address");
  AST_BUSY_FILTER: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && $past(core_busy) |-> req.op == nbci_pkg::NBCI_OP_STATUS || req.op == nbci_pkg::NBCI_OP_RESET)
    else $error("command accepted while busy");
  AST_HALF_ONCE: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && req.op == nbci_pkg::NBCI_OP_READ |-> !half_r)
    else $error("second half pointer not reverted");
  AST_RESET_PTR: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && req.op == nbci_pkg::NBCI_OP_RESET |-> !half_r && !spare_r && state_r == ST_IDLE)
    else $error("reset left pointer off first half");
  AST_WIDE_NO_B: assert property (@(posedge clk) disable iff (!nrst)
    cmd_stb && wide_bus && cmd == `NBCI_CMD_READ_B |=> !half_r)
    else $error("wide part took second half pointer");
  AST_READ_AFTER_FOUR: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && req.op == nbci_pkg::NBCI_OP_READ |-> $past(addr_cnt_r) == 3'h3)
    else $error("read issued without four address cycles");

  COV_PROG: cover property (@(posedge clk) disable iff (!nrst) req_valid && req.op == nbci_pkg::NBCI_OP_PROG);
  COV_ERASE: cover property (@(posedge clk) disable iff (!nrst) req_valid && req.op == nbci_pkg::NBCI_OP_ERASE);
  COV_READ_OUT: cover property (@(posedge clk) disable iff (!nrst) dout_ready && dout_valid);
  COV_FIFO_FULL: cover property (@(posedge clk) disable iff (!nrst) !fifo_in_ready);
endmodule

/* File: nbci_consts.svh */
// constants of the nand bus command interface
`ifndef NBCI_CONSTS_SVH
`define NBCI_CONSTS_SVH
`define NBCI_CMD_READ_A 8'h00
`define NBCI_CMD_READ_B 8'h01
`define NBCI_CMD_READ_C 8'h50
`define NBCI_CMD_SIG 8'h90
`define NBCI_CMD_STATUS 8'h70
`define NBCI_CMD_PROG 8'h80
`define NBCI_CMD_PROG_CONF 8'h10
`define NBCI_CMD_COPYBACK 8'h8a
`define NBCI_CMD_ERASE 8'h60
`define NBCI_CMD_ERASE_CONF 8'hd0
`define NBCI_CMD_RESET 8'hff
`define NBCI_ADDR_CYCLES 3'h4
`define NBCI_ADDR_W 26
`define NBCI_HALF_BIT 8
`define NBCI_IO_W 16
`define NBCI_FIFO_DEPTH 4
`endif

/* File: nbci_pkg.sv */
// types of the nand bus command interface
package nbci_pkg;
  typedef enum logic [2:0] {
    NBCI_OP_NONE,
    NBCI_OP_READ,
    NBCI_OP_PROG,
    NBCI_OP_ERASE,
    NBCI_OP_COPYBACK,
    NBCI_OP_SIG,
    NBCI_OP_STATUS,
    NBCI_OP_RESET
  } nbci_op_t;

  typedef struct packed {
    nbci_op_t op;
    logic spare_area;
    logic [25:0] addr;
  } nbci_req_t;

  typedef struct packed {
    logic ce_n;
    logic command_latch_enable;
    logic address_latch_enable;
    logic we_n;
    logic re_n;
  } nbci_ctl_t;
endpackage

/* File: nbci_host.sv */
// host controller model that drives the nand bus pins
module nbci_host (
  input wire logic clk,
  output nbci_pkg::nbci_ctl_t ctl,
  output logic wp_n,
  output logic [15:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    ctl = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    wp_n = 1'b1;
    io_in = 16'h0000;
  end

  // strobe low one clock, high two, io held past the sampled rise
  task automatic wr(input logic cle, input logic ale, input logic [15:0] v);
    @(posedge clk);
    ctl.command_latch_enable <= cle;
    ctl.address_latch_enable <= ale;
    ctl.we_n <= 1'b0;
    io_in <= v;
    @(posedge clk);
    ctl.we_n <= 1'b1;
    @(posedge clk);
    ctl.command_latch_enable <= 1'b0;
    ctl.address_latch_enable <= 1'b0;
    // released lines must not keep the last value
    io_in <= ~v;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] junk);
    wr(1'b1, 1'b0, {junk, c});
  endtask

  task automatic adr(input logic [25:0] a, input logic [7:0] junk);
    wr(1'b0, 1'b1, {junk, a[7:0]});
    wr(1'b0, 1'b1, {junk, a[16:9]});
    wr(1'b0, 1'b1, {junk, a[24:17]});
    wr(1'b0, 1'b1, {junk, 7'h00, a[25]});
  endtask

  task automatic dat(input logic [15:0] v);
    wr(1'b0, 1'b0, v);
  endtask

  task automatic rd();
    @(posedge clk);
    ctl.re_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    ctl.re_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic standby(input logic v);
    @(posedge clk);
    ctl.ce_n <= v;
  endtask

  task automatic guard(input logic v);
    @(posedge clk);
    wp_n <= v;
  endtask
endmodule

/* File: nbci_top_bench.sv */
// self-checking bench of the nand bus command interface
`include "nbci_consts.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module nbci_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic full;
    nbci_pkg::nbci_req_t r;
  } nbci_exp_t;

  logic clk, nrst, wide_bus, core_busy, din_ready, dout_valid, wp_n;
  logic [15:0] dout_data, io_out, io_oe, din_data, io_in;
  logic busy_indicator_o, busy_indicator_oe, req_valid, din_valid, dout_ready;
  nbci_pkg::nbci_ctl_t ctl;
  nbci_pkg::nbci_req_t req;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h6e80_83d9;
  nbci_exp_t req_q[$];
  nbci_exp_t mon_e;
  logic [15:0] din_q[$];
  logic [15:0] rd_q[$];
  logic [15:0] din_e;

  nbci_top uut (.clk(clk), .nrst(nrst), .wide_bus(wide_bus), .ctl(ctl), .wp_n(wp_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .busy_indicator_o(busy_indicator_o),
    .busy_indicator_oe(busy_indicator_oe), .core_busy(core_busy), .req(req), .req_valid(req_valid),
    .din_data(din_data), .din_valid(din_valid), .din_ready(din_ready), .dout_data(dout_data),
    .dout_valid(dout_valid), .dout_ready(dout_ready));

  nbci_host host (.clk(clk), .ctl(ctl), .wp_n(wp_n), .io_in(io_in));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic exp_req(input nbci_pkg::nbci_op_t op, input logic sp, input logic [25:0] a, input logic full);
    nbci_exp_t e;
    e.full = full;
    e.r.op = op;
    e.r.spare_area = sp;
    e.r.addr = a;
    req_q.push_back(e);
  endtask

  task automatic read_op(input logic [7:0] code, input logic half, input logic sp);
    logic [31:0] r;
    logic [25:0] a;
    r = rnd();
    a = r[25:0];
    a[8] = half;
    host.cmd(code, r[31:24]);
    `CHK("io_oe_cmd", 16'h0000, io_oe)
    exp_req(nbci_pkg::NBCI_OP_READ, sp, a, 1'b1);
    host.adr(a, r[29:22]);
  endtask

  task automatic read_word();
    logic [15:0] w;
    host.rd();
    `CHK("words_taken", 32'd1, rd_q.size())
    w = rd_q.pop_front();
    `CHK("io_out", w, io_out)
    `CHK("io_oe_out", 16'hffff, io_oe)
  endtask

  task automatic prog(input int n, input logic ok, input logic stall);
    logic [31:0] r;
    logic [25:0] a;
    r = rnd();
    a = r[25:0];
    a[8] = 1'b0;
    host.cmd(`NBCI_CMD_PROG, r[31:24]);
    host.adr(a, r[30:23]);
    for (int i = 0; i < n; i++)
    begin
      r = rnd();
      din_q.push_back(wide_bus ? r[15:0] : {8'h00, r[7:0]});
      host.dat(r[15:0]);
    end
    if (stall)
    begin
      @(posedge clk);
      `CHK("busy_fifo_full", 1'b1, busy_indicator_oe)
      din_ready <= 1'b1;
    end
    if (!ok)
      host.guard(1'b0);
    if (ok)
      exp_req(nbci_pkg::NBCI_OP_PROG, 1'b0, a, 1'b1);
    host.cmd(`NBCI_CMD_PROG_CONF, r[31:24]);
    host.guard(1'b1);
  endtask

  // core side: each taken word is replaced so stale data cannot pass
  always @(posedge clk)
  begin
    if (dout_ready === 1'b1)
    begin
      rd_q.push_back(wide_bus ? dout_data : {8'h00, dout_data[7:0]});
      dout_data <= dout_data + 16'h1357;
    end
  end

  always @(posedge clk)
  begin
    if (req_valid === 1'b1)
    begin
      if (req_q.size() == 0)
      begin
        error_cnt++;
        $display("MISMATCH req expected none seen %h", req);
      end
      else
      begin
        mon_e = req_q.pop_front();
        `CHK("req_op", mon_e.r.op, req.op)
        if (mon_e.full)
          `CHK("req", mon_e.r, req)
      end
    end
    if (din_valid === 1'b1 && din_ready === 1'b1)
    begin
      din_e = din_q.pop_front();
      `CHK("din_data", din_e, din_data)
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    results();
  end

  initial
  begin
    logic [31:0] r;
    logic [25:0] a;
    nrst = 1'b0;
    wide_bus = 1'b0;
    core_busy = 1'b0;
    din_ready = 1'b1;
    dout_valid = 1'b1;
    dout_data = 16'h00a5;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    read_op(`NBCI_CMD_READ_A, 1'b0, 1'b0);
    read_word();
    read_word();
    host.standby(1'b1);
    @(posedge clk);
    `CHK("io_oe_standby", 16'h0000, io_oe)
    host.standby(1'b0);
    read_op(`NBCI_CMD_READ_B, 1'b1, 1'b0);
    prog(3, 1'b1, 1'b0);
    prog(0, 1'b0, 1'b0);
    r = rnd();
    a = r[25:0];
    a[8] = 1'b0;
    host.cmd(`NBCI_CMD_ERASE, r[31:24]);
    host.adr(a, r[7:0]);
    // a fifth address cycle must leave the erase address alone
    host.wr(1'b0, 1'b1, ~r[15:0]);
    exp_req(nbci_pkg::NBCI_OP_ERASE, 1'b0, a, 1'b1);
    host.cmd(`NBCI_CMD_ERASE_CONF, r[15:8]);
    read_op(`NBCI_CMD_READ_A, 1'b0, 1'b0);
    r = rnd();
    a = r[25:0];
    a[8] = 1'b0;
    host.cmd(`NBCI_CMD_COPYBACK, r[31:24]);
    exp_req(nbci_pkg::NBCI_OP_COPYBACK, 1'b0, a, 1'b1);
    host.adr(a, r[7:0]);
    host.cmd(`NBCI_CMD_PROG_CONF, r[15:8]);
    // busy core: only status and reset may pass
    core_busy <= 1'b1;
    @(posedge clk);
    `CHK("busy_pin", 1'b1, busy_indicator_oe)
    `CHK("busy_value", 1'b0, busy_indicator_o)
    host.cmd(`NBCI_CMD_READ_A, r[23:16]);
    host.adr(a, r[7:0]);
    exp_req(nbci_pkg::NBCI_OP_STATUS, 1'b0, a, 1'b0);
    host.cmd(`NBCI_CMD_STATUS, r[15:8]);
    exp_req(nbci_pkg::NBCI_OP_RESET, 1'b0, a, 1'b0);
    host.cmd(`NBCI_CMD_RESET, r[7:0]);
    core_busy <= 1'b0;
    host.cmd(8'h33, r[31:24]);
    host.cmd(`NBCI_CMD_PROG_CONF, r[23:16]);
    host.cmd(`NBCI_CMD_ERASE_CONF, r[15:8]);
    exp_req(nbci_pkg::NBCI_OP_SIG, 1'b0, a, 1'b0);
    host.cmd(`NBCI_CMD_SIG, r[7:0]);
    read_word();
    read_op(`NBCI_CMD_READ_C, 1'b0, 1'b1);
    read_op(`NBCI_CMD_READ_A, 1'b0, 1'b0);
    din_ready <= 1'b0;
    prog(`NBCI_FIFO_DEPTH, 1'b1, 1'b1);
    repeat (6) @(posedge clk);
    // second reset, now strapped as a sixteen-bit part
    nrst <= 1'b0;
    wide_bus <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    r = rnd();
    a = r[25:0];
    host.cmd(`NBCI_CMD_READ_B, r[31:24]);
    host.adr(a, r[7:0]);
    read_op(`NBCI_CMD_READ_A, 1'b0, 1'b0);
    read_word();
    prog(2, 1'b1, 1'b0);
    for (int i = 0; i < 50 && (req_q.size() + din_q.size()) != 0; i++)
      @(posedge clk);
    `CHK("left_over", 32'd0, req_q.size() + din_q.size())
    results();
  end
endmodule
